// file: hdl/irq_detect.v
// external interrupt synchroniser and level/edge detector
`timescale 1ns/1ns
`default_nettype none
`include "pbus_defines.vh"
module irq_detect #(
   parameter N = `IRQ_N
) (
   // clock and reset
   input  wire         ref_clk,
   input  wire         rst,
   // pins
   input  wire [N-1:0] irq_lines_n,
   input  wire         edge_sel,
   // to core
   output reg  [N-1:0] irq_pending
);
   reg [N-1:0] s1_q;
   reg [N-1:0] s2_q;
   reg [N-1:0] s3_q;
   reg         e1_q;
   reg         e2_q;
   genvar i;
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s1_q <= {N{1'b1}};
         s2_q <= {N{1'b1}};
         s3_q <= {N{1'b1}};
         e1_q <= 1'b0;
         e2_q <= 1'b0;
      end else begin
         s1_q <= irq_lines_n;
         s2_q <= s1_q;
         s3_q <= s2_q;
         e1_q <= edge_sel;
         e2_q <= e1_q;
      end
   end
   generate
      for (i = 0; i < N; i = i + 1) begin : g_irq
         // edge mode: one pulse per falling edge; level mode: held while low
         always @(posedge ref_clk or posedge rst) begin
            if (rst)
               irq_pending[i] <= 1'b0;
            else if (e2_q)
               irq_pending[i] <= s3_q[i] & ~s2_q[i];
            else
               irq_pending[i] <= ~s2_q[i];
         end
      end
   endgenerate
endmodule
`default_nettype wire

// file: hdl/pbus_defines.vh
// constants for the primary bus port and control pins
`ifndef PBUS_DEFINES_VH
`define PBUS_DEFINES_VH
`define ADDR_W        24
`define DATA_W        32
`define PAGE_W        2
`define PAGE_LSB      22
`define IRQ_N         4
`define BOOT_LOADER   1'b1
// bus sequencer states
`define ST_IDLE       2'h0
`define ST_ACCESS     2'h1
`define ST_RELEASED   2'h2
// ready synchroniser depth: edges before ready reflects this access
`define RDY_SETTLE    2'h2
`endif

// file: hdl/primary_bus.v
// primary external bus port with release handshake and control pins
`timescale 1ns/1ns
`default_nettype none
`include "pbus_defines.vh"
module primary_bus (
   // clock and reset
   input  wire                 ref_clk,
   input  wire                 rst,
   // control pins
   input  wire                 reset_pin_n,
   input  wire                 shutdown_float_n,
   input  wire                 boot_mode_select,
   input  wire                 irq_edge_select,
   input  wire [`IRQ_N-1:0]    external_irq_lines_n,
   input  wire                 bus_release_req_n,
   input  wire                 ready_n,
   // core side request
   input  wire                 core_req,
   input  wire                 core_rd,
   input  wire [`ADDR_W-1:0]   core_addr,
   input  wire [`DATA_W-1:0]   core_wdata,
   input  wire                 ignore_release_bit,
   input  wire                 irq_ack_out_exec,
   output wire                 core_busy,
   output reg                  core_done,
   output reg  [`DATA_W-1:0]   core_rdata,
   output wire                 core_in_reset,
   output reg                  boot_loader_mode,
   output wire [`IRQ_N-1:0]    irq_pending,
   // bus pins
   output reg  [`ADDR_W-1:0]   address_lines,
   output wire                 address_oe,
   input  wire [`DATA_W-1:0]   data_lines_in,
   output wire [`DATA_W-1:0]   data_lines_out,
   output wire                 data_oe,
   output wire                 rd_not_wr,
   output wire                 rd_not_wr_oe,
   output wire                 access_strobe_n,
   output wire                 access_strobe_oe,
   output wire [3:0]           region_select_strobes_n,
   output wire                 region_select_oe,
   output wire                 bus_release_ack_n,
   output wire                 bus_release_ack_oe,
   output wire                 irq_ack_out_n,
   output wire                 irq_ack_out_oe
);
   reg [1:0]         sz_q;
   reg [1:0]         rs_q;
   reg [1:0]         hd_q;
   reg [1:0]         rdy_q;
   reg [1:0]         boot_q;
   reg [1:0]         st_q;
   reg [1:0]         st_d;
   reg               rd_q;
   reg [`DATA_W-1:0] wdata_q;
   reg [`DATA_W-1:0] keep_q;
   reg               irq_ack_out_q;
   reg               ack_q;
   // cycles spent in the current access, saturating at RDY_SETTLE
   reg [1:0]         age_q;
   wire shutdown_float    = ~sz_q[1];
   wire in_rst = ~rs_q[1];
   wire hold   = ~hd_q[1] & ~ignore_release_bit;
   wire rdy    = ~rdy_q[1];
   // a memory may hold ready until the strobe ends, so the synchroniser
   // still shows the previous access's ready for two edges; skip those
   wire acc_ok = (st_q == `ST_ACCESS) & rdy & (age_q == `RDY_SETTLE);
   wire released = (st_q == `ST_RELEASED);
   wire float_all = shutdown_float | in_rst | released;

   function [3:0] page_decode;
      input [`PAGE_W-1:0] sel;
      begin
         page_decode = ~(4'h1 << sel);
      end
   endfunction

   irq_detect #(.N(`IRQ_N)) irq_detect_i (
      .ref_clk     (ref_clk),
      .rst         (rst),
      .irq_lines_n (external_irq_lines_n),
      .edge_sel    (irq_edge_select),
      .irq_pending (irq_pending)
   );

   // pin synchronisers
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sz_q   <= 2'h3;
         rs_q   <= 2'h0;
         hd_q   <= 2'h3;
         rdy_q  <= 2'h3;
         boot_q <= 2'h0;
      end else begin
         sz_q   <= {sz_q[0], shutdown_float_n};
         rs_q   <= {rs_q[0], reset_pin_n};
         hd_q   <= {hd_q[0], bus_release_req_n};
         rdy_q  <= {rdy_q[0], ready_n};
         boot_q <= {boot_q[0], boot_mode_select};
      end
   end

   assign core_in_reset = in_rst;

   always @* begin
      st_d = st_q;
      case (st_q)
         `ST_IDLE:
            if (hold)
               st_d = `ST_RELEASED;
            else if (core_req)
               st_d = `ST_ACCESS;
         `ST_ACCESS:
            if (acc_ok)
               st_d = `ST_IDLE;
         `ST_RELEASED:
            if (!hold)
               st_d = `ST_IDLE;
         default:
            st_d = `ST_IDLE;
      endcase
   end

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_q             <= `ST_IDLE;
         rd_q             <= 1'b1;
         address_lines    <= {`ADDR_W{1'b0}};
         wdata_q          <= {`DATA_W{1'b0}};
         keep_q           <= {`DATA_W{1'b0}};
         core_done        <= 1'b0;
         core_rdata       <= {`DATA_W{1'b0}};
         irq_ack_out_q           <= 1'b0;
         ack_q            <= 1'b1;
         age_q            <= 2'h0;
         boot_loader_mode <= 1'b0;
      end else if (in_rst) begin
         // core reset: bus idle, boot strap tracked until release
         st_q             <= `ST_IDLE;
         core_done        <= 1'b0;
         irq_ack_out_q           <= 1'b0;
         ack_q            <= 1'b1;
         age_q            <= 2'h0;
         boot_loader_mode <= boot_q[1] == `BOOT_LOADER;
         // keeper: remember the last level seen on the wires
         keep_q           <= data_oe ? wdata_q : data_lines_in;
      end else begin
         st_q      <= st_d;
         core_done <= acc_ok;
         keep_q    <= data_oe ? wdata_q : data_lines_in;
         if (st_q == `ST_IDLE)
            age_q <= 2'h0;
         else if (st_q == `ST_ACCESS && age_q != `RDY_SETTLE)
            age_q <= age_q + 2'h1;
         irq_ack_out_q    <= irq_ack_out_exec;
         // ack follows the float, so it is low only once pins are off
         ack_q     <= ~released;
         if (st_q == `ST_IDLE && st_d == `ST_ACCESS) begin
            rd_q          <= core_rd;
            address_lines <= core_addr;
            wdata_q       <= core_wdata;
         end
         if (acc_ok && rd_q)
            core_rdata <= data_lines_in;
      end
   end

   assign core_busy        = (st_q != `ST_IDLE) | in_rst;
   assign address_oe       = ~float_all;
   assign rd_not_wr        = rd_q;
   assign rd_not_wr_oe     = ~float_all;
   assign data_oe          = ~float_all & (st_q == `ST_ACCESS) & ~rd_q;
   assign data_lines_out   = data_oe ? wdata_q : keep_q;
   assign access_strobe_n  = ~(st_q == `ST_ACCESS);
   assign access_strobe_oe = ~(shutdown_float | released);
   assign region_select_strobes_n = (st_q == `ST_ACCESS) ?
      page_decode(address_lines[`PAGE_LSB+`PAGE_W-1:`PAGE_LSB]) : 4'hF;
   assign region_select_oe   = ~float_all;
   // ack rises in the cycle the bus is taken back, never after the pins drive
   assign bus_release_ack_n  = ack_q | ~released;
   assign bus_release_ack_oe = ~shutdown_float;
   assign irq_ack_out_n      = ~irq_ack_out_q;
   assign irq_ack_out_oe     = ~shutdown_float;
endmodule
`default_nettype wire

// file: sim/mem_partner.sv
// external memory model answering the primary bus
`timescale 1ns/1ns
`default_nettype none
module mem_partner (
   // clock and pins
   input wire logic ref_clk, access_strobe_n, access_strobe_oe, rd_not_wr,
   input wire logic [23:0] address_lines,
   input wire logic [31:0] data_lines_out,
   input wire logic [3:0] wait_cycles,
   output var logic ready_n,
   output var logic [31:0] mem_rdata
);
   logic [31:0] mem [0:15];
   logic [3:0] cnt_q = 4'h0;
   initial ready_n = 1'b1;
   // ready held until strobe ends, so slow sync still sees it
   always @(posedge ref_clk) begin
      if (access_strobe_n || !access_strobe_oe) begin
         ready_n <= #5 1'b1;
         cnt_q <= 4'h0;
      end else if (cnt_q < wait_cycles) begin
         cnt_q <= cnt_q + 4'h1;
      end else begin
         ready_n <= #5 1'b0;
         if (!rd_not_wr) mem[address_lines[3:0]] <= data_lines_out;
         mem_rdata <= #5 mem[address_lines[3:0]];
      end
   end
endmodule
`default_nettype wire

// file: sim/pbus_monitor.sv
// assertion checker for the primary bus port
`timescale 1ns/1ns
`default_nettype none
`include "pbus_defines.vh"
module pbus_monitor (
   // clock, reset, core side
   input wire logic ref_clk, rst, core_rd, core_done, ignore_release_bit,
   input wire logic [`ADDR_W-1:0] core_addr, address_lines,
   // pins
   input wire logic ready_n, shutdown_float_n, bus_release_req_n, bus_release_ack_n,
   input wire logic address_oe, data_oe, rd_not_wr, rd_not_wr_oe,
   input wire logic access_strobe_n, access_strobe_oe, region_select_oe,
   input wire logic [3:0] region_select_strobes_n
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_launch; $fell(access_strobe_n); endsequence
   sequence s_float; !address_oe && !data_oe && !rd_not_wr_oe && !access_strobe_oe; endsequence
   AST_DIR: assert property (s_launch |-> rd_not_wr == $past(core_rd))
      else $error("direction wrong");
   AST_ADDR: assert property (s_launch |-> address_oe && address_lines == $past(core_addr))
      else $error("address wrong");
   AST_REGION: assert property (!access_strobe_n && region_select_oe
      |-> region_select_strobes_n == ~(4'h1 << address_lines[23:22])) else $error("region wrong");
   AST_READY: assert property (core_done |-> !$past(ready_n, 3))
      else $error("done without ready");
   AST_ACCESS_STROBE: assert property (!access_strobe_n && access_strobe_oe |=> access_strobe_oe || core_done)
      else $error("strobe floated mid access");
   AST_FLOAT: assert property (!bus_release_ack_n |-> s_float)
      else $error("bus driven while released");
   AST_ACKLOW: assert property ($fell(bus_release_ack_n) |-> $past(!address_oe && !access_strobe_oe))
      else $error("ack before float");
   AST_ACKHI: assert property ((bus_release_req_n || ignore_release_bit) [*6] |-> bus_release_ack_n)
      else $error("ack stuck low");
   AST_SHZ: assert property (!shutdown_float_n [*4] |-> s_float ##0 !region_select_oe)
      else $error("pins driven in shutdown");
endmodule
`default_nettype wire

// file: sim/tb_primary_bus.sv
// self-checking bench for the primary bus port
`timescale 1ns/1ns
`default_nettype none
`include "pbus_defines.vh"
module tb_primary_bus;
   logic ref_clk, rst, reset_pin_n, shutdown_float_n, boot_mode_select, irq_edge_select;
   logic bus_release_req_n, ready_n, core_req, core_rd, ignore_release_bit, irq_ack_out_exec;
   logic [3:0] external_irq_lines_n, irq_pending, region_select_strobes_n, wait_cycles;
   logic [23:0] core_addr, address_lines;
   logic [31:0] core_wdata, core_rdata, data_lines_in, data_lines_out, mem_rdata;
   logic core_busy, core_done, core_in_reset, boot_loader_mode, address_oe, data_oe;
   logic rd_not_wr, rd_not_wr_oe, access_strobe_n, access_strobe_oe, region_select_oe;
   logic bus_release_ack_n, bus_release_ack_oe, irq_ack_out_n, irq_ack_out_oe;
   int n_fail = 0, checks_done = 0, i;
   primary_bus primary_bus_i (.*);
   mem_partner mem_partner_i (.*);
   // device keeper holds the last level when memory is not driving
   assign data_lines_in = (!data_oe && rd_not_wr && !access_strobe_n) ? mem_rdata : data_lines_out;
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   task automatic check(input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #5;
   endtask
   task automatic await(ref logic s, input logic v);
      for (i = 0; i < 200 && s !== v; i++) tick(1);
      if (s !== v) begin
         n_fail++;
         finish_test;
      end
   endtask
   task automatic bus_op(input logic rd, input logic [23:0] a, input logic [31:0] d);
      await(core_busy, 1'b0);
      core_rd = rd; core_addr = a; core_wdata = d; core_req = 1'b1;
      tick(1);
      core_req = 1'b0;
      await(core_done, 1'b1);
      if (rd) check(core_rdata, d);
   endtask
   task automatic sc_bus;
      for (int r = 0; r < 4; r++) begin
         wait_cycles = r;
         bus_op(1'b0, {r[1:0], 18'h0, r[3:0]}, 32'hC0DE0000 + r);
      end
      for (int r = 0; r < 4; r++) bus_op(1'b1, {r[1:0], 18'h0, r[3:0]}, 32'hC0DE0000 + r);
   endtask
   task automatic sc_release;
      bus_release_req_n = 1'b0;
      await(bus_release_ack_n, 1'b0);
      check(address_oe, 1'b0);
      core_req = 1'b1;
      tick(4);
      check({core_busy, access_strobe_oe}, 2'h2);
      ignore_release_bit = 1'b1;
      await(bus_release_ack_n, 1'b1);
      await(core_done, 1'b1);
      core_req = 1'b0;
      check(core_rdata, 32'hC0DE0003);
      bus_release_req_n = 1'b1;
      tick(6);
      ignore_release_bit = 1'b0;
   endtask
   task automatic sc_irq;
      external_irq_lines_n = 4'hE; irq_ack_out_exec = 1'b1;
      tick(1);
      irq_ack_out_exec = 1'b0;
      await(irq_ack_out_n, 1'b0);
      tick(3);
      check(irq_pending, 4'h1);
      external_irq_lines_n = 4'hF; irq_edge_select = 1'b1;
      tick(4);
      external_irq_lines_n = 4'h7;
      tick(3);
      check(irq_pending, 4'h8);
      tick(3);
      check(irq_pending, 4'h0);
   endtask
   task automatic sc_shz;
      shutdown_float_n = 1'b0;
      tick(4);
      check({address_oe, data_oe, rd_not_wr_oe, access_strobe_oe, region_select_oe,
         bus_release_ack_oe, irq_ack_out_oe}, 7'h0);
      shutdown_float_n = 1'b1; reset_pin_n = 1'b0; boot_mode_select = 1'b1;
      tick(4);
      check({core_in_reset, region_select_oe, address_oe}, 3'h4);
      reset_pin_n = 1'b1;
      tick(4);
      check({core_in_reset, boot_loader_mode}, {1'b0, `BOOT_LOADER});
   endtask
   initial begin
      rst = 1'b1; reset_pin_n = 1'b0; shutdown_float_n = 1'b1; boot_mode_select = 1'b0;
      irq_edge_select = 1'b0; external_irq_lines_n = 4'hF; bus_release_req_n = 1'b1;
      core_req = 1'b0; core_rd = 1'b0; core_addr = 24'h0; core_wdata = 32'h0;
      ignore_release_bit = 1'b0; irq_ack_out_exec = 1'b0; wait_cycles = 4'h0;
      tick(5);
      rst = 1'b0; reset_pin_n = 1'b1;
      await(core_in_reset, 1'b0);
      sc_bus;
      sc_release;
      sc_irq;
      sc_shz;
      finish_test;
   end
endmodule
bind primary_bus pbus_monitor pbus_monitor_i (.*);
`default_nettype wire
